// >>> common/pm_pkg.sv
package pm_pkg;

    typedef enum logic [6:0] {
        ST_RUN   = 7'b0000001,
        ST_SLEEP = 7'b0000010,
        ST_DEEP  = 7'b0000100,
        ST_LATCH = 7'b0001000,
        ST_OSCW  = 7'b0010000,
        ST_CALL  = 7'b0100000,
        ST_HOLD  = 7'b1000000
    } pm_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // control outputs toward the core, clock tree and pads
    typedef struct packed {
        logic        cpu_clk_en;
        logic        periph_clk_en;
        logic        osc_run;
        logic        ale_low;
        logic        program_store_strobe_low;
        logic        port_hold;
        logic        sfr_freeze;
        logic        periph_freeze;
        logic        int_global_en;
        logic        fetch_discard;
        logic        wake_irq;
        logic [15:0] wake_vector;
    } pm_ctrl_t;

    // pin inputs, used both before and after synchronisation
    typedef struct packed {
        logic ext_interrupt0_pin;
        logic can_rx;
        logic osc_stable;
    } pm_pins_t;

endpackage : pm_pkg

// >>> common/pm_regs.svh
`ifndef PM_REGS_SVH
`define PM_REGS_SVH

// register indices; byte address is four times the index
`define PM_CTRL_IDX      8'h87
`define PM_EXT_IDX       8'h88
`define PM_SYSCFG_IDX    8'hb1
`define PM_STAT_IDX      8'hc0

// power_control_reg fields
`define PM_SLEEP_ARM_BIT 0
`define PM_DEEP_ARM_BIT  1
`define PM_SLOW_BIT      4
`define PM_SLEEP_GO_BIT  5
`define PM_DEEP_GO_BIT   6
// power_control_ext fields
`define PM_WAKE_SEL_BIT  4
`define PM_PIN_WAKE_BIT  7
// system_config field
`define PM_MAP_BIT       4

// reset values
`define PM_CTRL_RST      8'h00
`define PM_EXT_RST       8'h00
`define PM_SYSCFG_RST    8'h00

// timing
`define PM_SLOW_DIV      32
`define PM_MC_CLKS       6
`define PM_CLK_NS        25
`define PM_WAKE_LOW_NS   10000
`define PM_WAKE_LOW_CLKS ((`PM_WAKE_LOW_NS + `PM_CLK_NS - 1) / `PM_CLK_NS)
`define PM_CALL_MCS      2
`define PM_WAKE_VEC      16'h007b

`endif

// >>> dv/pm_wake_src.sv
`timescale 1ns/1ps
module pm_wake_src
#(
    parameter int LOW_CLKS = 420,
    parameter int OSC_DLY  = 20
)
(
    // clock
    input  wire logic        pclk,
    // bench requests
    input  wire logic        wake_go,
    input  wire logic        use_can,
    // oscillator state at the device
    input  wire logic        osc_run,
    // wake pins and oscillator watchdog
    output pm_pkg::pm_pins_t pins
);
    import pm_pkg::*;
    int   low_n = 0;
    int   osc_n = 0;
    logic can_q = 1'b0;
    // pins idle high, low for more than 10 us only when waking
    always @(posedge pclk)
    begin
        if (wake_go)
            can_q <= use_can;
        low_n <= wake_go ? LOW_CLKS : (low_n > 0 ? low_n - 1 : 0);
        osc_n <= osc_run ? (osc_n < OSC_DLY ? osc_n + 1 : osc_n) : 0;
    end
    // a stopped oscillator is reported unstable from the first clock edge after it stops
    assign pins.ext_interrupt0_pin       = !(low_n > 0 && !can_q);
    assign pins.can_rx     = !(low_n > 0 && can_q);
    assign pins.osc_stable = osc_n >= OSC_DLY;
endmodule : pm_wake_src

// >>> dv/power_saving_mode_control_asserts.sv
`timescale 1ns/1ps
module power_saving_mode_control_asserts
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // register bus
    input  wire pm_pkg::apb_req_t  apb_req,
    input  wire pm_pkg::apb_rsp_t  apb_rsp,
    // core events
    input  wire logic              int_request,
    input  wire logic              return_from_interrupt_done,
    // pins
    input  wire pm_pkg::pm_pins_t  pins_async,
    // controls
    input  wire pm_pkg::pm_ctrl_t  pm_ctrl
);
    import pm_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    strobes_low_a: assert property (!pm_ctrl.osc_run |->
        pm_ctrl.ale_low && pm_ctrl.program_store_strobe_low) else $error("strobes high");
    state_frozen_a: assert property (!pm_ctrl.osc_run |->
        pm_ctrl.sfr_freeze && pm_ctrl.port_hold) else $error("not frozen");
    wake_vec_a: assert property (pm_ctrl.wake_vector == 16'h007b)
        else $error("bad vector");
    irq_pulse_a: assert property (pm_ctrl.wake_irq |=>
        !pm_ctrl.wake_irq) else $error("irq too long");
    irq_call_a: assert property (pm_ctrl.wake_irq |->
        pm_ctrl.fetch_discard && !pm_ctrl.ale_low && pm_ctrl.osc_run)
        else $error("call not started");
    call_len_a: assert property ($rose(pm_ctrl.fetch_discard) |->
        ##11 pm_ctrl.fetch_discard ##1 !pm_ctrl.fetch_discard)
        else $error("call length");
    int_blocked_a: assert property (pm_ctrl.periph_freeze |->
        !pm_ctrl.int_global_en) else $error("interrupts open");
    freeze_end_a: assert property (return_from_interrupt_done &&
        pm_ctrl.periph_freeze && !pm_ctrl.fetch_discard
        |=> !pm_ctrl.periph_freeze) else $error("freeze kept");
    start_zero_a: assert property (apb_req.psel && apb_req.penable &&
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 12'h21c
        |-> apb_rsp.prdata[6:5] == 2'h0 && apb_rsp.prdata[1:0] == 2'h0)
        else $error("start bits read set");
endmodule : power_saving_mode_control_asserts

// >>> dv/power_saving_mode_control_tb.sv
`timescale 1ns/1ps
`include "pm_regs.svh"
module power_saving_mode_control_tb;
    import pm_pkg::*;
    localparam logic [11:0] A_CTRL = {2'h0, `PM_CTRL_IDX, 2'h0};
    localparam logic [11:0] A_EXT  = {2'h0, `PM_EXT_IDX, 2'h0};
    localparam logic [11:0] A_SYS  = {2'h0, `PM_SYSCFG_IDX, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, `PM_STAT_IDX, 2'h0};
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    apb_req_t    req         = '0;
    apb_rsp_t    rsp;
    logic        int_request = 1'b0;
    logic        return_from_interrupt_done   = 1'b0;
    logic        wake_go     = 1'b0;
    logic        use_can     = 1'b0;
    pm_pins_t    pins;
    pm_ctrl_t    ctl;
    int          err_total   = 0;
    int          cmp_count   = 0;
    logic [31:0] rd;
    logic        serr;

    always #12.5 pclk = ~pclk;

    power_saving_mode_control dut (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .int_request(int_request),
        .return_from_interrupt_done(return_from_interrupt_done), .pins_async(pins), .pm_ctrl(ctl));
    pm_wake_src far (.pclk(pclk), .wake_go(wake_go), .use_can(use_can),
        .osc_run(ctl.osc_run), .pins(pins));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // one transfer, then an idle cycle so back to back calls never collide
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        serr = rsp.pslverr;
        req <= '0;
        @(posedge pclk);
        if (n >= 20)
        begin
            err_total++;
            test_done();
        end
    endtask : apb

    task automatic t_regs();
        apb(1, A_EXT, 8'h90);
        apb(0, A_EXT, 0);
        chk(rd, 0);
        apb(1, A_SYS, 8'h10);
        apb(0, A_EXT, 0);
        chk(rd, 0);
        apb(1, A_EXT, 8'h10);
        apb(0, A_EXT, 0);
        chk(rd, 32'h10);
        apb(1, A_EXT, 8'h00);
        apb(1, A_SYS, 8'h00);
        apb(0, 12'h004, 0);
        chk(serr, 1);
        apb(1, A_CTRL, 8'h8f);
        apb(0, A_CTRL, 0);
        chk(rd, 32'h8c);
        apb(1, A_CTRL, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_slow();
        int c;
        int p;
        apb(1, A_CTRL, 8'h10);
        tick(12);
        c = 0;
        p = 0;
        repeat (64)
        begin
            @(posedge pclk);
            c += ctl.cpu_clk_en;
            p += ctl.periph_clk_en;
        end
        chk(c, 2);
        chk(p, 2);
        apb(1, A_CTRL, 8'h00);
        c = 0;
        repeat (4)
        begin
            @(posedge pclk);
            c += ctl.cpu_clk_en;
        end
        chk(c, 4);
        $display("test slow done");
    endtask : t_slow

    task automatic t_sleep();
        apb(1, A_CTRL, 8'h01);
        apb(1, A_CTRL, 8'h30);
        tick(40);
        chk({ctl.cpu_clk_en, ctl.osc_run}, 2'b01);
        apb(0, A_STAT, 0);
        chk({rd[8], rd[6:0]}, 8'h82);
        int_request <= 1'b1;
        tick(1);
        int_request <= 1'b0;
        tick(2);
        apb(0, A_STAT, 0);
        chk({rd[8], rd[6:0]}, 8'h81);
        apb(0, A_CTRL, 0);
        chk(rd, 32'h10);
        apb(1, A_CTRL, 8'h00);
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_deep();
        apb(1, A_CTRL, 8'h02);
        apb(1, A_CTRL, 8'h42);
        tick(3);
        chk(ctl.osc_run, 1);
        apb(1, A_CTRL, 8'h02);
        apb(1, A_CTRL, 8'hc0);
        tick(2);
        chk({ctl.osc_run, ctl.ale_low, ctl.program_store_strobe_low}, 3'b011);
        chk({ctl.port_hold, ctl.sfr_freeze}, 2'b11);
        wake_go <= 1'b1;
        tick(1);
        wake_go <= 1'b0;
        tick(600);
        chk(ctl.osc_run, 0);
        presetn <= 1'b0;
        tick(12);                    // two machine cycles of reset
        presetn <= 1'b1;
        tick(3);
        chk(ctl.osc_run, 1);
        apb(0, A_CTRL, 0);
        chk(rd, 0);
        $display("test deep reset done");
    endtask : t_deep

    // arm 02 gives power down; arm 03 asks for sleep too, power down wins
    task automatic t_wake(input logic can, input logic [7:0] arm);
        int n;
        apb(1, A_SYS, 8'h10);
        apb(1, A_EXT, {1'b1, 2'h0, can, 4'h0});
        apb(1, A_SYS, 8'h00);
        chk(ctl.int_global_en, 0);
        apb(1, A_CTRL, arm);
        apb(1, A_CTRL, {2'b11, arm[0], 5'h0});
        chk(ctl.osc_run, 0);
        use_can <= can;
        wake_go <= 1'b1;
        tick(1);
        wake_go <= 1'b0;
        n = 0;
        while (ctl.wake_irq !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000)
        begin
            err_total++;
            test_done();
        end
        chk(n >= 400, 1);
        chk({ctl.fetch_discard, ctl.wake_vector}, {1'b1, 16'h007b});
        chk({ctl.periph_freeze, ctl.osc_run}, 2'b11);
        tick(20);
        return_from_interrupt_done <= 1'b1;
        tick(1);
        return_from_interrupt_done <= 1'b0;
        tick(2);
        chk(ctl.periph_freeze, 0);
        apb(0, A_CTRL, 0);
        chk(rd, 32'h80);
        apb(1, A_SYS, 8'h10);
        apb(1, A_EXT, 8'h00);
        apb(1, A_SYS, 8'h00);
        apb(1, A_CTRL, 8'h00);
        $display("test wake done");
    endtask : t_wake

    initial
    begin
        tick(8);
        presetn <= 1'b1;
        tick(2);
        t_regs();
        t_slow();
        t_sleep();
        t_deep();
        t_wake(1'b0, 8'h02);
        t_wake(1'b1, 8'h03);
        test_done();
    end
endmodule : power_saving_mode_control_tb

bind power_saving_mode_control power_saving_mode_control_asserts chk_i (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .int_request(int_request), .return_from_interrupt_done(return_from_interrupt_done),
    .pins_async(pins_async), .pm_ctrl(pm_ctrl));

// >>> rtl/pm_sync2.sv
`timescale 1ns/1ps
module pm_sync2
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // asynchronous pins in, synchronised out
    input  wire pm_pkg::pm_pins_t  pins_async,
    output pm_pkg::pm_pins_t       pins_sync
);
    import pm_pkg::*;

    typedef struct packed {
        pm_pins_t meta;
        pm_pins_t stable;
    } sync_state_t;

    // pins idle high, so reset to high avoids a false wake edge
    localparam sync_state_t SYNC_RST = '{meta: 3'b111, stable: 3'b111};

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb
    begin
        s_d        = s_q;
        s_d.meta   = pins_async;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= SYNC_RST;
        else
            s_q <= s_d;
    end

    assign pins_sync = s_q.stable;

endmodule : pm_sync2

// >>> rtl/power_saving_mode_control.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`include "pm_regs.svh"
// What this block does
// [R01] slow down divides cpu and peripheral clock enables by 32
// [R02] slow down starts at next machine cycle boundary, within two cycles
// [R03] clearing slow_down_enable returns to full rate at once
// [R04] sleep_arm then sleep_start with slow_down_enable enters sleep plus slow
// [R05] interrupt ending sleep leaves slow_down_enable set
// [R06] after wake the cpu resumes at the next instruction
// [R07] reset source holds reset two machine cycles to end sleep
// [R08] power down stops both oscillators, storage kept
// [R09] port pins hold latch or last alternate output in power down
// [R10] address and program strobes held low in power down
// [R11] reset exit returns registers to reset state, oscillators restart
// [R12] pin exit restarts oscillators, registers stay frozen
// [R13] deep_stop_arm write, then deep_stop_start write enters power down
// [R14] arm and start in one write never enters power down
// [R15] arm and start bits self clear and read as zero
// [R16] without pin_wake_enable only reset leaves power down
// [R17] pin_wake_enable gates all interrupts, enable bits untouched
// [R18] pin wake set in power_control_ext through mapped select, bit 4 source
// [R19] wake pin low for 10 us starts oscillators and latches the pin
// [R20] stable oscillator raises wake interrupt at vector 007b
// [R21] strobes low until call; fetches during two-cycle call discarded
// [R22] timers, can, watchdog frozen, interrupts blocked until return
// [R23] sleep_arm write, then sleep_start write enters sleep; bits self clear
// [R24] wake_source_select resets to zero, ext_interrupt0_pin
// [R25] power down wins over sleep; slow down on both clock enables
module power_saving_mode_control
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // register bus
    input  wire pm_pkg::apb_req_t  apb_req,
    output pm_pkg::apb_rsp_t       apb_rsp,
    // core events, same clock
    input  wire logic              int_request,
    input  wire logic              return_from_interrupt_done,
    // pins and oscillator watchdog, asynchronous
    input  wire pm_pkg::pm_pins_t  pins_async,
    // control toward core, clocks and pads
    output pm_pkg::pm_ctrl_t       pm_ctrl
);
    import pm_pkg::*;

    localparam logic [8:0] WAKE_LAST = 9'(`PM_WAKE_LOW_CLKS - 1);
    localparam logic [8:0] CALL_LAST = 9'(`PM_CALL_MCS * `PM_MC_CLKS - 1);
    localparam logic [2:0] MC_LAST   = 3'(`PM_MC_CLKS - 1);
    localparam logic [4:0] DIV_LAST  = 5'(`PM_SLOW_DIV - 1);

    typedef struct packed {
        pm_state_t   st;
        logic [7:0]  ctrl;
        logic [7:0]  ext;
        logic [7:0]  syscfg;
        logic        sleep_armed;
        logic        deep_armed;
        logic        slow_act;
        logic [4:0]  div;
        logic [2:0]  mc;
        logic [8:0]  cnt;
        apb_rsp_t    rsp;
        pm_ctrl_t    o;
    } pm_regs_t;

    localparam pm_ctrl_t CTRL_RST = '{
        cpu_clk_en:    1'b1,
        periph_clk_en: 1'b1,
        osc_run:       1'b1,
        ale_low:       1'b0,
        program_store_strobe_low:      1'b0,
        port_hold:     1'b0,
        sfr_freeze:    1'b0,
        periph_freeze: 1'b0,
        int_global_en: 1'b1,
        fetch_discard: 1'b0,
        wake_irq:      1'b0,
        wake_vector:   `PM_WAKE_VEC
    };

    // reset also ends power down: registers back to reset, oscillators on
    localparam pm_regs_t PM_RST = '{
        st:          ST_RUN,
        ctrl:        `PM_CTRL_RST,
        ext:         `PM_EXT_RST, // [R24]
        syscfg:      `PM_SYSCFG_RST,
        sleep_armed: 1'b0,
        deep_armed:  1'b0,
        slow_act:    1'b0,
        div:         5'h00,
        mc:          3'h0,
        cnt:         9'h000,
        rsp:         '0,
        o:           CTRL_RST
    }; // [R11]

    pm_regs_t r_q;
    pm_regs_t r_d;
    pm_pins_t pins;

    pm_sync2 u_sync
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .pins_async (pins_async),
        .pins_sync  (pins)
    );

    // 0 none, 1 control, 2 ext, 3 sysconfig, 4 status
    function automatic logic [2:0] reg_sel(input logic [11:0] addr);
        logic [2:0] s;
        s = 3'd0;
        if (addr[1:0] == 2'b00)
        begin
            case (addr[9:2])
                `PM_CTRL_IDX:   s = 3'd1;
                `PM_EXT_IDX:    s = 3'd2;
                `PM_SYSCFG_IDX: s = 3'd3;
                `PM_STAT_IDX:   s = 3'd4;
                default:        s = 3'd0;
            endcase
        end
        if (addr[11:10] != 2'b00)
            s = 3'd0;
        return s;
    endfunction : reg_sel

    // states in which the core fetches and executes
    function automatic logic core_runs(input pm_state_t s);
        logic v;
        case (s)
            ST_RUN,
            ST_CALL,
            ST_HOLD: v = 1'b1;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : core_runs

    // oscillators stay stopped until the latch phase has passed
    function automatic logic osc_stopped(input pm_state_t s);
        logic v;
        case (s)
            ST_DEEP,
            ST_LATCH: v = 1'b1;
            default:  v = 1'b0;
        endcase
        return v;
    endfunction : osc_stopped

    // strobes low and pads parked until the wake call starts
    function automatic logic pads_parked(input pm_state_t s);
        logic v;
        case (s)
            ST_DEEP,
            ST_LATCH,
            ST_OSCW: v = 1'b1;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : pads_parked

    // timers, can and watchdog held from the latch phase to the return
    function automatic logic wake_frozen(input pm_state_t s);
        logic v;
        case (s)
            ST_LATCH,
            ST_OSCW,
            ST_CALL,
            ST_HOLD: v = 1'b1;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : wake_frozen

    // shared by the latch and call phase counters
    function automatic logic [8:0] step9(input logic [8:0] v);
        return v + 9'h001;
    endfunction : step9

    logic [2:0] sel;
    logic       setup;
    logic       wr_fire;
    logic [7:0] w;
    logic       mapped;
    logic       wake_pin;
    logic       deep_go;
    logic       sleep_go;
    logic       full_rate;

    always_comb
    begin
        r_d      = r_q;
        sel      = reg_sel(apb_req.paddr);
        setup    = apb_req.psel && !apb_req.penable;
        // registers stay as frozen at entry while the pads are parked
        wr_fire  = apb_req.psel && apb_req.penable && r_q.rsp.pready
                   && apb_req.pwrite && !r_q.o.sfr_freeze; // [R12]
        w        = apb_req.pwdata[7:0];
        mapped   = r_q.syscfg[`PM_MAP_BIT];
        deep_go  = 1'b0;
        sleep_go = 1'b0;
        // [R18]
        wake_pin = r_q.ext[`PM_WAKE_SEL_BIT] ? pins.can_rx : pins.ext_interrupt0_pin;

        // bus answer: data prepared in setup, ready in the access cycle
        r_d.rsp.pready  = setup;
        r_d.rsp.pslverr = 1'b0;
        r_d.rsp.prdata  = 32'h0000_0000;
        if (setup)
        begin
            r_d.rsp.pslverr = (sel == 3'd0);
            case (sel)
                3'd1:    r_d.rsp.prdata = {24'h00_0000, r_q.ctrl}; // [R15]
                3'd2:    r_d.rsp.prdata = mapped
                             ? {24'h00_0000, r_q.ext} : 32'h0000_0000;
                3'd3:    r_d.rsp.prdata = {24'h00_0000, r_q.syscfg};
                3'd4:    r_d.rsp.prdata = {23'h00_0000, r_q.slow_act,
                                           1'b0, r_q.st};
                default: r_d.rsp.prdata = 32'h0000_0000;
            endcase
        end

        if (wr_fire)
        begin
            case (sel)
                3'd1:
                begin
                    // arm and start bits never stored, so they read zero
                    r_d.ctrl = {w[7], 2'b00, w[`PM_SLOW_BIT], w[3:2],
                                2'b00}; // [R15]
                    deep_go  = w[`PM_DEEP_GO_BIT] && !w[`PM_DEEP_ARM_BIT]
                               && r_q.deep_armed; // [R13] [R14]
                    sleep_go = w[`PM_SLEEP_GO_BIT] && !w[`PM_SLEEP_ARM_BIT]
                               && r_q.sleep_armed; // [R23]
                    // any other write to the register disarms both
                    r_d.deep_armed  = w[`PM_DEEP_ARM_BIT]
                                      && !w[`PM_DEEP_GO_BIT]; // [R14]
                    r_d.sleep_armed = w[`PM_SLEEP_ARM_BIT]
                                      && !w[`PM_SLEEP_GO_BIT];
                end
                3'd2:
                begin
                    if (mapped)
                        r_d.ext = {w[`PM_PIN_WAKE_BIT], 2'b00,
                                   w[`PM_WAKE_SEL_BIT], 4'h0}; // [R18]
                end
                3'd3:    r_d.syscfg = {3'b000, w[`PM_MAP_BIT], 4'h0};
                default: r_d.syscfg = r_q.syscfg;
            endcase
        end

        // free-running machine cycle and slow divider counters
        r_d.mc  = (r_q.mc == MC_LAST) ? 3'h0 : r_q.mc + 3'h1;
        r_d.div = (r_q.div == DIV_LAST) ? 5'h00 : r_q.div + 5'h01;
        if (!r_q.ctrl[`PM_SLOW_BIT])
            r_d.slow_act = 1'b0; // [R03]
        else if (r_q.mc == MC_LAST)
            r_d.slow_act = 1'b1; // [R02]

        r_d.o.wake_irq = 1'b0;
        case (r_q.st)
            ST_RUN:
            begin
                // power down takes precedence over sleep
                if (deep_go)
                    r_d.st = ST_DEEP; // [R13] [R25]
                else if (sleep_go)
                    r_d.st = ST_SLEEP; // [R04] [R23]
            end
            ST_SLEEP:
            begin
                // slow_down_enable is left alone here
                if (int_request)
                    r_d.st = ST_RUN; // [R05] [R06]
            end
            ST_DEEP:
            begin
                r_d.cnt = 9'h000;
                if (r_q.ext[`PM_PIN_WAKE_BIT] && !wake_pin)
                    r_d.st = ST_LATCH; // [R16] [R19]
            end
            ST_LATCH:
            begin
                // a low pulse shorter than the latch phase is ignored
                if (wake_pin)
                    r_d.st = ST_DEEP;
                else if (r_q.cnt == WAKE_LAST)
                    r_d.st = ST_OSCW; // [R19]
                else
                    r_d.cnt = step9(r_q.cnt);
            end
            ST_OSCW:
            begin
                r_d.cnt = 9'h000;
                if (pins.osc_stable)
                begin
                    r_d.st         = ST_CALL;
                    r_d.o.wake_irq = 1'b1; // [R20]
                end
            end
            ST_CALL:
            begin
                if (r_q.cnt == CALL_LAST)
                    r_d.st = ST_HOLD; // [R21]
                else
                    r_d.cnt = step9(r_q.cnt);
            end
            ST_HOLD:
            begin
                if (return_from_interrupt_done)
                    r_d.st = ST_RUN; // [R22] [R06]
            end
            default: r_d.st = ST_RUN;
        endcase

        // outputs follow the next state so they leave the flops aligned
        full_rate = !r_d.slow_act || (r_d.div == 5'h00); // [R01]
        r_d.o.cpu_clk_en    = full_rate && core_runs(r_d.st); // [R25]
        r_d.o.periph_clk_en = full_rate && (core_runs(r_d.st)
                              || r_d.st == ST_SLEEP); // [R25]
        r_d.o.osc_run       = !osc_stopped(r_d.st); // [R08] [R12]
        r_d.o.ale_low       = pads_parked(r_d.st); // [R10] [R21]
        r_d.o.program_store_strobe_low      = r_d.o.ale_low; // [R10]
        r_d.o.port_hold     = r_d.o.ale_low; // [R09]
        r_d.o.sfr_freeze    = r_d.o.ale_low; // [R12]
        r_d.o.periph_freeze = wake_frozen(r_d.st); // [R22]
        // stored enable bits elsewhere are untouched; only the gate drops
        r_d.o.int_global_en = !r_d.ext[`PM_PIN_WAKE_BIT]
                              && !r_d.o.periph_freeze; // [R17] [R22]
        r_d.o.fetch_discard = (r_d.st == ST_CALL); // [R21]
        r_d.o.wake_vector   = `PM_WAKE_VEC; // [R20]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_q <= PM_RST; // [R11] [R07]
        else
            r_q <= r_d;
    end

    assign apb_rsp = r_q.rsp;
    assign pm_ctrl = r_q.o;

endmodule : power_saving_mode_control
